// ### logic/dssp_defs.svh
// Purpose: offsets, field positions, reset values and counts of the serial slave port
// Assumes: configuration address space of 32 byte registers
// Notes:   address byte is read flag plus register index
`ifndef DSSP_DEFS_SVH
`define DSSP_DEFS_SVH

`define DSSP_ADDR_W        5
`define DSSP_MODE_ADDR     5'h00
`define DSSP_MODE_RST      8'h20
`define DSSP_RD_BIT        6
`define DSSP_MOD_HI        7
`define DSSP_MOD_LO        5
`define DSSP_PATH_HI       4
`define DSSP_PATH_LO       3
`define DSSP_OP_SLEEP      3'h0
`define DSSP_OP_STBY       3'h1
`define DSSP_OP_FS         3'h2
`define DSSP_OP_RX         3'h3
`define DSSP_OP_TX         3'h4
`define DSSP_FIFO_BYTES    64
`define DSSP_BUF_DEPTH     2

`endif

// ### logic/dssp_pkg.sv
// Purpose: shared types of the serial slave port
// Assumes: nothing beyond the defs header
// Notes:   pin enables travel as one struct
package dssp_pkg;

  typedef enum logic [1:0] {
    DSSP_PATH_CONT,
    DSSP_PATH_BUF,
    DSSP_PATH_PKT
  } dssp_path_t;

  typedef struct packed {
    logic irq0;
    logic irq1;
    logic data;
    logic clkout;
  } dssp_pin_oe_t;

endpackage : dssp_pkg

// ### logic/dssp_port.sv
// Purpose: dual-select serial slave port, config registers and fifo byte framing
// Assumes: host master drives sck, mosi and both selects; sck idles between frames
// Notes:   sck domain holds shift logic; mclk domain holds registers and buffering
`timescale 1ns/100ps
`include "dssp_defs.svh"

module dssp_port #(
  parameter int REGS       = 32,
  parameter int FIFO_BYTES = `DSSP_FIFO_BYTES
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 sck,
  input  wire logic                 config_select_n,
  input  wire logic                 fifo_select_n,
  input  wire logic                 mosi,
  output logic                      miso_o,
  output logic                      miso_oe,
  input  wire logic                 data_pin_i,
  output logic                      data_pin_o,
  input  wire logic                 rx_bit,
  output logic                      tx_bit,
  output logic [7:0]                push_data,
  output logic                      push_valid,
  input  wire logic                 push_ready,
  output logic                      push_busy,
  output logic                      push_overrun,
  input  wire logic [7:0]           pop_data,
  input  wire logic                 pop_valid,
  output logic                      pop_ready,
  output logic [2:0]                module_mode,
  output dssp_pkg::dssp_path_t      path_mode,
  output dssp_pkg::dssp_pin_oe_t    pin_oe
);
  import dssp_pkg::*;

  localparam int AW = `DSSP_ADDR_W;
  localparam int CW = $clog2(FIFO_BYTES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // select decode for the sck domain and the miso enable; mclk decodes its own synced copy

  logic cfg_sel;
  logic dat_sel;
  logic frame_idle;

  assign cfg_sel    = ~config_select_n;
  assign dat_sel    = config_select_n & ~fifo_select_n;
  assign frame_idle = config_select_n & fifo_select_n;
  // line direction must follow the pins at once, so this gate is not registered
  assign miso_oe    = ~frame_idle;

  ////////////////////////////////////////////////////////////////////////////////
  // sck domain: shift in, address/value phase, staged writes

  logic [2:0]    bit_cnt;
  logic [2:0]    next_bit_cnt;
  logic          started;
  logic          cfg_phase;
  logic          next_cfg_phase;
  logic [7:0]    shin;
  logic [7:0]    next_shin;
  logic [AW-1:0] cfg_addr;
  logic [AW-1:0] next_cfg_addr;
  logic          cfg_rd;
  logic          next_cfg_rd;
  logic [7:0]    data_byte;
  logic [7:0]    next_data_byte;
  logic          data_got;
  logic          next_data_got;
  logic [7:0]    shadow [REGS];
  logic [REGS-1:0] dirty;
  logic [REGS-1:0] next_dirty;
  logic          stage_we;
  logic [7:0]    rx_byte;
  logic          miso_q;
  logic [7:0]    miso_src;
  logic [7:0]    active [REGS];
  logic [7:0]    hold_byte;

  always_comb
  begin
    rx_byte        = {shin[6:0], mosi};
    next_bit_cnt   = bit_cnt + 3'h1;
    next_shin      = rx_byte;
    next_cfg_phase = cfg_phase;
    next_cfg_addr  = cfg_addr;
    next_cfg_rd    = cfg_rd;
    next_data_byte = data_byte;
    next_data_got  = data_got;
    next_dirty     = dirty;
    stage_we       = 1'b0;
    // first edge of a frame forgets what the previous frame left behind
    if (!started && cfg_sel)
      next_dirty = '0;
    if (!started && dat_sel)
      next_data_got = 1'b0;
    if (bit_cnt == 3'h7)
    begin
      if (cfg_sel)
      begin
        next_cfg_phase = ~cfg_phase;
        if (!cfg_phase)
        begin
          next_cfg_addr = rx_byte[AW-1:0];
          next_cfg_rd   = rx_byte[`DSSP_RD_BIT];
        end
        else if (!cfg_rd)
        begin
          stage_we             = 1'b1;
          next_dirty[cfg_addr] = 1'b1;
        end
      end
      else if (dat_sel)
      begin
        next_data_byte = rx_byte;
        next_data_got  = 1'b1;
      end
    end
  end

  // frame counters clear while no select is low, so every frame starts aligned
  always_ff @(posedge sck or posedge frame_idle)
  begin
    if (frame_idle)
    begin
      bit_cnt   <= 3'h0;
      cfg_phase <= 1'b0;
      started   <= 1'b0;
    end
    else
    begin
      bit_cnt   <= next_bit_cnt;
      cfg_phase <= next_cfg_phase;
      started   <= 1'b1;
    end
  end

  // these must outlive the frame so mclk can read them after the select rises
  always_ff @(posedge sck)
  begin
    shin      <= next_shin;
    cfg_addr  <= next_cfg_addr;
    cfg_rd    <= next_cfg_rd;
    data_byte <= next_data_byte;
    data_got  <= next_data_got;
    dirty     <= next_dirty;
    if (stage_we)
      shadow[cfg_addr] <= rx_byte;
  end

  // active changes only after the config select rises and hold_byte only while the
  // fifo select is high, so they are stable across any frame that reads them here
  always_comb
  begin
    miso_src = cfg_sel ? active[cfg_addr] : hold_byte;
  end

  always_ff @(negedge sck)
  begin
    miso_q <= miso_src[3'h7 - bit_cnt];
  end

  // msb of a data read must stand before the first rising edge
  assign miso_o = started ? miso_q : hold_byte[7];

  ////////////////////////////////////////////////////////////////////////////////
  // mclk domain: three-stage capture of selects and data pin

  localparam int SW = 3;
  logic [SW-1:0] sy1;
  logic [SW-1:0] sy2;
  logic [SW-1:0] sy3;
  logic [SW-1:0] sy_q;
  logic [SW-1:0] next_sy_q;

  generate
    for (genvar i = 0; i < SW; i++)
    begin : g_sync
      always_comb
      begin
        next_sy_q[i] = (sy2[i] == sy3[i]) ? sy3[i] : sy_q[i];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    sy1 <= {data_pin_i, fifo_select_n, config_select_n};
    sy2 <= sy1;
    sy3 <= sy2;
    if (srst)
      sy_q <= 3'h3;
    else
      sy_q <= next_sy_q;
  end

  logic cfg_rise;
  logic dat_rise;
  logic dat_low;

  assign cfg_rise = ~sy_q[0] & next_sy_q[0];
  // data frames only count while config was high, mirroring the pin priority
  assign dat_rise = ~sy_q[1] & next_sy_q[1] & sy_q[0];
  assign dat_low  = ~sy_q[1] | ~next_sy_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // mclk domain: configuration registers and mode decode

  logic [2:0]     mod_fld;
  logic [1:0]     path_fld;
  dssp_path_t     path_dec;
  logic           fifo_mode;

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < REGS; i++)
    begin
      if (srst)
        active[i] <= (i == int'(`DSSP_MODE_ADDR)) ? `DSSP_MODE_RST : 8'h00;
      else if (cfg_rise && dirty[i])
        active[i] <= shadow[i];
    end
  end

  always_comb
  begin
    mod_fld  = active[`DSSP_MODE_ADDR][`DSSP_MOD_HI:`DSSP_MOD_LO];
    path_fld = active[`DSSP_MODE_ADDR][`DSSP_PATH_HI:`DSSP_PATH_LO];
    if (path_fld[1])
      path_dec = DSSP_PATH_PKT;
    else if (path_fld[0])
      path_dec = DSSP_PATH_BUF;
    else
      path_dec = DSSP_PATH_CONT;
    fifo_mode = (path_dec != DSSP_PATH_CONT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mclk domain: pin directions and continuous pass-through

  dssp_pin_oe_t next_pin_oe;
  logic         irq_on;

  always_comb
  begin
    unique case (mod_fld)
      `DSSP_OP_SLEEP: irq_on = 1'b0;
      `DSSP_OP_STBY,
      `DSSP_OP_FS:    irq_on = fifo_mode;
      default:        irq_on = 1'b1;
    endcase
    next_pin_oe.irq0   = irq_on;
    next_pin_oe.irq1   = irq_on;
    next_pin_oe.data   = (mod_fld == `DSSP_OP_RX);
    next_pin_oe.clkout = (mod_fld != `DSSP_OP_SLEEP);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_oe      <= '0;
      module_mode <= `DSSP_OP_STBY;
      path_mode   <= DSSP_PATH_CONT;
      data_pin_o  <= 1'b0;
      tx_bit      <= 1'b0;
    end
    else
    begin
      pin_oe      <= next_pin_oe;
      module_mode <= mod_fld;
      path_mode   <= path_dec;
      // bits bypass the fifo only in continuous mode
      data_pin_o  <= fifo_mode ? 1'b0 : rx_bit;
      tx_bit      <= fifo_mode ? 1'b0 : sy_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mclk domain: read prefetch, write push, two-entry buffer

  logic [7:0]    buf_mem [`DSSP_BUF_DEPTH];
  logic [1:0]    buf_cnt;
  logic [1:0]    next_buf_cnt;
  logic          buf_rd;
  logic          next_buf_rd;
  logic          buf_wr;
  logic          next_buf_wr;
  logic          hold_valid;
  logic          next_hold_valid;
  logic [7:0]    next_hold_byte;
  logic          next_pop_ready;
  logic          next_overrun;
  logic [CW-1:0] pay_cnt;
  logic [CW-1:0] next_pay_cnt;
  logic [2:0]    mod_prev;
  logic          do_push;
  logic          do_pop;

  always_comb
  begin
    next_hold_valid = hold_valid;
    next_hold_byte  = hold_byte;
    next_overrun    = push_overrun;
    next_pay_cnt    = pay_cnt;
    next_buf_rd     = buf_rd;
    next_buf_wr     = buf_wr;
    do_pop          = push_valid & push_ready;
    do_push         = 1'b0;
    if (pop_valid && pop_ready)
    begin
      next_hold_valid = 1'b1;
      next_hold_byte  = pop_data;
    end
    // a packet payload restarts with each change of module mode
    if (path_dec != DSSP_PATH_PKT || mod_fld != mod_prev)
      next_pay_cnt = '0;
    if (dat_rise && data_got && fifo_mode)
    begin
      if (hold_valid)
        next_hold_valid = 1'b0;
      else if (path_dec == DSSP_PATH_PKT && pay_cnt == CW'(FIFO_BYTES))
        next_overrun = 1'b1;
      else if (buf_cnt == 2'(`DSSP_BUF_DEPTH) && !do_pop)
        next_overrun = 1'b1;
      else
      begin
        do_push = 1'b1;
        if (path_dec == DSSP_PATH_PKT)
          next_pay_cnt = pay_cnt + CW'(1);
      end
    end
    if (do_push)
      next_buf_wr = ~buf_wr;
    if (do_pop)
      next_buf_rd = ~buf_rd;
    next_buf_cnt = buf_cnt + {1'b0, do_push} - {1'b0, do_pop};
    // no prefetch while a data frame runs, so miso sees a steady byte
    next_pop_ready = ~next_hold_valid & ~dat_low & fifo_mode;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      hold_valid   <= 1'b0;
      hold_byte    <= 8'h00;
      pop_ready    <= 1'b0;
      push_overrun <= 1'b0;
      pay_cnt      <= '0;
      mod_prev     <= `DSSP_OP_STBY;
      buf_cnt      <= 2'h0;
      buf_rd       <= 1'b0;
      buf_wr       <= 1'b0;
      push_busy    <= 1'b0;
    end
    else
    begin
      hold_valid   <= next_hold_valid;
      hold_byte    <= next_hold_byte;
      pop_ready    <= next_pop_ready;
      push_overrun <= next_overrun;
      pay_cnt      <= next_pay_cnt;
      mod_prev     <= mod_fld;
      buf_cnt      <= next_buf_cnt;
      buf_rd       <= next_buf_rd;
      buf_wr       <= next_buf_wr;
      push_busy    <= (next_buf_cnt == 2'(`DSSP_BUF_DEPTH));
    end
    if (do_push)
      buf_mem[buf_wr] <= data_byte;
  end

  // head entry and its valid are registered from buffer state, with data_byte passed through when a push lands at the head
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      push_valid <= 1'b0;
      push_data  <= 8'h00;
    end
    else
    begin
      push_valid <= (next_buf_cnt != 2'h0);
      push_data  <= (do_push && (next_buf_cnt == 2'h1) && !(buf_cnt == 2'h1 && !do_pop))
                    ? data_byte : buf_mem[next_buf_rd];
    end
  end

endmodule : dssp_port

// ### verification/dssp_host_model.sv
// Purpose: host master on the shared serial lines
// Assumes: sck idles low and stands still between frames
// Notes:   mosi shows the inverse of its last bit while unused
`timescale 1ns/100ps
module dssp_host_model (
  output logic      sck,
  output logic      mosi,
  output logic      config_select_n,
  output logic      fifo_select_n,
  input  wire logic miso
);
  initial
  begin
    {sck, mosi} = 2'h0;
    // late rise of the selects gives the frame reset an edge it cannot miss
    #1;
    {config_select_n, fifo_select_n} = 2'h3;
  end
  ////////////////////////////////////////////////////////////////
  // odd offset keeps sck edges clear of mclk edges
  task automatic open_frame(input logic cfg_n, input logic dat_n);
    #37.3;
    config_select_n = cfg_n;
    fifo_select_n = dat_n;
    #80;
  endtask : open_frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      #80 sck = 1'b1;
      rx[i] = miso;
      #80 sck = 1'b0;
    end
  endtask : xfer
  // data frames carry one byte each; callers keep to that
  task automatic close_frame();
    #80;
    config_select_n = 1'b1;
    fifo_select_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask : close_frame
endmodule : dssp_host_model

// ### verification/dssp_port_props.sv
// Purpose: port checks of the serial slave port
// Assumes: config frames are apart by at least 10 mclk
// Notes:   pin enables and module_mode move on the same mclk edge
`timescale 1ns/100ps
`include "dssp_defs.svh"
module dssp_port_props (
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire logic                   config_select_n,
  input wire logic                   fifo_select_n,
  input wire logic                   miso_oe,
  input wire logic                   rx_bit,
  input wire logic                   data_pin_o,
  input wire logic [7:0]             push_data,
  input wire logic                   push_valid,
  input wire logic                   push_ready,
  input wire logic                   push_overrun,
  input wire logic                   pop_valid,
  input wire logic                   pop_ready,
  input wire logic [2:0]             module_mode,
  input wire dssp_pkg::dssp_path_t   path_mode,
  input wire dssp_pkg::dssp_pin_oe_t pin_oe
);
  import dssp_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  function automatic logic irq_on(logic [2:0] m, dssp_path_t p);
    return m > `DSSP_OP_FS || (m != `DSSP_OP_SLEEP && p != DSSP_PATH_CONT);
  endfunction : irq_on
  ////////////////////////////////////////////////////////////////
  chk_oe_select: assert property (miso_oe == (!config_select_n || !fifo_select_n))
    else $error("miso enable off its selects");
  // a commit lands 4-5 mclk after the rise, never inside a long frame
  chk_hold_commit: assert property (!config_select_n && !$past(config_select_n, 6)
    |-> $stable(module_mode) && $stable(path_mode)) else $error("mode moved mid frame");
  chk_pin_dir: assert property (!$past(srst) |->
    pin_oe.clkout == (module_mode != `DSSP_OP_SLEEP)
    && pin_oe.data == (module_mode == `DSSP_OP_RX)) else $error("pin direction wrong");
  chk_irq_oe: assert property (!$past(srst) |-> pin_oe.irq1 == pin_oe.irq0
    && pin_oe.irq0 == irq_on(module_mode, path_mode)) else $error("irq enable");
  chk_push_hold: assert property (push_valid && !push_ready |=> push_valid && $stable(push_data))
    else $error("push word lost");
  chk_cont_quiet: assert property (path_mode == DSSP_PATH_CONT && $stable(path_mode)
    |-> !$rose(push_valid) && !pop_ready) else $error("fifo used in continuous");
  chk_cont_copy: assert property (!$past(srst) && $stable(path_mode) |->
    data_pin_o == (path_mode == DSSP_PATH_CONT && $past(rx_bit))) else $error("data pin copy");
  chk_pop_once: assert property (pop_valid && pop_ready |=> !pop_ready)
    else $error("second pop while held");
  chk_overrun_keep: assert property (push_overrun |=> push_overrun)
    else $error("overrun flag dropped");
  cov_push: cover property (push_valid && push_ready);
  cov_pop: cover property (pop_valid && pop_ready);
  cov_over: cover property ($rose(push_overrun));
  cov_both: cover property (!config_select_n && !fifo_select_n);
endmodule : dssp_port_props

// ### verification/dssp_port_tb.sv
// Purpose: self-checking bench of the serial slave port
// Assumes: host model owns the serial lines
// Notes:   a quiet gap follows each frame so commits land first
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dssp_port_tb;
  import dssp_pkg::*;
  logic         mclk, srst, sck, config_select_n, fifo_select_n, mosi, miso, miso_o, miso_oe;
  logic         data_pin_i, data_pin_o, rx_bit, tx_bit, push_valid, push_ready, push_busy;
  logic         push_overrun, pop_valid, pop_ready;
  logic [7:0]   push_data, pop_data, r;
  logic [2:0]   module_mode;
  dssp_path_t   path_mode;
  dssp_pin_oe_t pin_oe;
  int           miscompares = 0, n_tests = 0, cyc = 0, n_push = 0;
  // line has a pull-up while released
  assign miso = miso_oe ? miso_o : 1'b1;
  dssp_host_model i_host (.sck, .mosi, .config_select_n, .fifo_select_n, .miso);
  dssp_port i_dut (.mclk, .srst, .sck, .config_select_n, .fifo_select_n, .mosi, .miso_o,
    .miso_oe, .data_pin_i, .data_pin_o, .rx_bit, .tx_bit, .push_data, .push_valid, .push_ready,
    .push_busy, .push_overrun, .pop_data, .pop_valid, .pop_ready, .module_mode, .path_mode,
    .pin_oe);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // one count per accepted word, taken where valid and ready have settled
  always @(negedge mclk)
  begin
    if (push_valid === 1'b1 && push_ready === 1'b1)
      n_push++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic gap();
    repeat (10) @(posedge mclk);
    @(negedge mclk);
  endtask : gap
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic dat_n);
    i_host.open_frame(1'b0, dat_n);
    i_host.xfer(a, r);
    i_host.xfer(v, r);
    i_host.close_frame();
    gap();
  endtask : wr
  task automatic df(input logic [7:0] v);
    i_host.open_frame(1'b1, 1'b0);
    i_host.xfer(v, r);
    i_host.close_frame();
    gap();
  endtask : df
  function automatic logic [7:0] mv(int m, int p);
    return {m[2:0], p[1:0], 3'h0};
  endfunction : mv
  ////////////////////////////////////////////////////////////////
  task automatic t_commit();
    `CHK("rst path", DSSP_PATH_CONT, path_mode)
    `CHK("rst pin_oe", 4'h1, pin_oe)
    i_host.open_frame(1'b0, 1'b1);
    i_host.xfer(8'h00, r);
    i_host.xfer(mv(4, 1), r);
    #400;
    `CHK("mid frame", 3'h1, module_mode)
    i_host.xfer(8'h00, r);
    i_host.xfer(mv(2, 2), r);
    i_host.close_frame();
    gap();
    `CHK("burst mode", 3'h2, module_mode)
    `CHK("burst path", DSSP_PATH_PKT, path_mode)
  endtask : t_commit
  task automatic t_modes();
    dssp_pin_oe_t e;
    dssp_path_t   ep;
    for (int m = 0; m < 5; m++)
      for (int p = 0; p < 4; p++)
      begin
        wr(8'h00, mv(m, p), 1'b1);
        ep = p == 0 ? DSSP_PATH_CONT : (p == 1 ? DSSP_PATH_BUF : DSSP_PATH_PKT);
        e.irq0 = m > 2 || (m != 0 && p != 0);
        e.irq1 = e.irq0;
        e.data = m == 3;
        e.clkout = m != 0;
        `CHK("path_mode", ep, path_mode)
        `CHK("pin_oe", e, pin_oe)
      end
  endtask : t_modes
  task automatic t_read();
    logic [7:0] v0, v1;
    wr(8'h01, 8'h5C, 1'b1);
    i_host.open_frame(1'b0, 1'b1);
    i_host.xfer(8'h41, r);
    i_host.xfer(8'h00, v1);
    i_host.xfer(8'h40, r);
    i_host.xfer(8'h00, v0);
    i_host.close_frame();
    gap();
    `CHK("read reg1", 8'h5C, v1)
    `CHK("read reg0", mv(4, 3), v0)
  endtask : t_read
  task automatic t_fifo_wr();
    int j;
    wr(8'h00, mv(1, 1), 1'b0);
    `CHK("both low path", DSSP_PATH_BUF, path_mode)
    `CHK("both low push", 1'b0, push_valid)
    df(8'hA0);
    `CHK("push_data", 8'hA0, push_data)
    df(8'hA1);
    `CHK("push_busy", 1'b1, push_busy)
    df(8'hA2);
    `CHK("push_overrun", 1'b1, push_overrun)
    @(posedge mclk);
    push_ready <= 1'b1;
    j = 0;
    repeat (12)
    begin
      @(negedge mclk);
      if (push_valid === 1'b1 && j < 3)
      begin
        `CHK("drained", 8'hA0 + j, push_data)
        j++;
      end
    end
    `CHK("drain count", 2, j)
    @(posedge mclk);
    push_ready <= 1'b0;
  endtask : t_fifo_wr
  task automatic t_fifo_rd();
    @(posedge mclk);
    pop_data <= 8'h3C;
    pop_valid <= 1'b1;
    repeat (8)
    begin
      @(negedge mclk);
      if (pop_ready === 1'b1)
        break;
    end
    @(posedge mclk);
    pop_valid <= 1'b0;
    pop_data <= 8'h00;
    gap();
    `CHK("pop held", 1'b0, pop_ready)
    df(8'hFF);
    `CHK("popped", 8'h3C, r)
    `CHK("read no push", 1'b0, push_valid)
    `CHK("pop free", 1'b1, pop_ready)
  endtask : t_fifo_rd
  // packet payload stops at fifo capacity; the byte after it is dropped
  task automatic t_cap();
    wr(8'h00, mv(4, 2), 1'b1);
    @(posedge mclk);
    push_ready <= 1'b1;
    n_push = 0;
    repeat (65) df(8'h6B);
    `CHK("packet cap", 64, n_push)
    @(posedge mclk);
    push_ready <= 1'b0;
  endtask : t_cap
  task automatic t_cont();
    wr(8'h00, mv(3, 0), 1'b1);
    df(8'h55);
    `CHK("cont push", 1'b0, push_valid)
    @(posedge mclk);
    rx_bit <= 1'b1;
    data_pin_i <= 1'b1;
    gap();
    `CHK("data_pin_o", 1'b1, data_pin_o)
    `CHK("tx_bit", 1'b1, tx_bit)
  endtask : t_cont
  initial
  begin
    {srst, rx_bit, data_pin_i, push_ready, pop_valid} = 5'h10;
    pop_data = 8'h00;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    t_commit();
    t_modes();
    t_read();
    t_fifo_wr();
    t_fifo_rd();
    t_cap();
    t_cont();
    stop_test();
  end
endmodule : dssp_port_tb
bind dssp_port dssp_port_props i_props (.mclk, .srst, .config_select_n, .fifo_select_n,
  .miso_oe, .rx_bit, .data_pin_o, .push_data, .push_valid, .push_ready, .push_overrun,
  .pop_valid, .pop_ready, .module_mode, .path_mode, .pin_oe);
